/* File: hw/adc_shared_gpio_ports_bcd.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module adc_shared_gpio_ports_bcd (
    input  wire logic                          CLK,
    input  wire logic                          RESET,
    input  wire logic [3:0]                    ADDR,
    input  wire logic [7:0]                    WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [7:0]                    RDATA,
    input  wire logic [gpio_pkg::ANALOG_W-1:0] ANALOG_PIN_IN,
    output logic      [gpio_pkg::ANALOG_W-1:0] ANALOG_PIN_OUT,
    output logic      [gpio_pkg::ANALOG_W-1:0] ANALOG_PIN_OE_N,
    input  wire logic [gpio_pkg::CLOCK_W-1:0]  CLOCK_PIN_IN,
    output logic      [gpio_pkg::CLOCK_W-1:0]  CLOCK_PIN_OUT,
    output logic      [gpio_pkg::CLOCK_W-1:0]  CLOCK_PIN_OE_N,
    input  wire logic [gpio_pkg::SEVEN_W-1:0]  SEVEN_PIN_IN,
    output logic      [gpio_pkg::SEVEN_W-1:0]  SEVEN_PIN_OUT,
    output logic      [gpio_pkg::SEVEN_W-1:0]  SEVEN_PIN_OE_N,
    output logic      [gpio_pkg::CHAN_W-1:0]   CONVERTER_CHANNEL_SELECT
);
    import gpio_pkg::*;

    // all block state in one record
    typedef struct packed {
        logic [ANALOG_W-1:0] analog_data;               // latch, no reset
        logic [ANALOG_W-1:0] analog_dir;
        logic [CLOCK_W-1:0]  clock_data;                // latch, no reset
        logic [CLOCK_W-1:0]  clock_dir;
        logic                clk_out_en;
        logic [SEVEN_W-1:0]  seven_data;                // latch, no reset
        logic [SEVEN_W-1:0]  seven_dir;
        logic [CHAN_W-1:0]   chan_sel;
        logic                analog_loaded;             // latch written since power-up, no reset
        logic [7:0]          rdata;
    } state_s;

    state_s r;                                           // registered state
    state_s next_r;                                      // next state

    logic [ANALOG_W-1:0] analog_sync;                    // synchronised pin levels
    logic [CLOCK_W-1:0]  clock_sync;
    logic [SEVEN_W-1:0]  seven_sync;
    logic [14:0]         chan_hot;                       // one-hot converter channel

    pin_sync #(.W(ANALOG_W)) u_sync_analog (
        .CLK   (CLK),
        .RESET (RESET),
        .D     (ANALOG_PIN_IN),
        .Q     (analog_sync)
    );
    pin_sync #(.W(CLOCK_W)) u_sync_clock (
        .CLK   (CLK),
        .RESET (RESET),
        .D     (CLOCK_PIN_IN),
        .Q     (clock_sync)
    );
    pin_sync #(.W(SEVEN_W)) u_sync_seven (
        .CLK   (CLK),
        .RESET (RESET),
        .D     (SEVEN_PIN_IN),
        .Q     (seven_sync)
    );

    chan_decode u_chan (
        .SEL (r.chan_sel),
        .HOT (chan_hot)
    );

    logic [ANALOG_W-1:0] analog_chan;                    // analog pins in converter use
    logic [SEVEN_W-1:0]  seven_chan;                     // seven-bit pins in converter use
    assign analog_chan = chan_hot[ANALOG_W-1:0];
    assign seven_chan  = chan_hot[14:8];

    // read mux: latch for outputs, pin (or zero on converter channel) for inputs
    function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                             input logic [7:0] pin, input logic [7:0] chan);
        port_read = (dir & latch) | (~dir & pin & ~chan);
    endfunction : port_read

    logic [7:0] clock_read;                              // clock port read value
    always_comb begin
        clock_read = port_read({3'h0, r.clock_data}, {3'h0, r.clock_dir},
                               {3'h0, clock_sync}, 8'h00);
        if (r.clk_out_en) begin
            clock_read[CLK_PIN_BIT] = 1'b0;
        end
    end

    // next-state: bus writes and registered read data
    always_comb begin
        next_r       = r;
        next_r.rdata = 8'h00;                            // unmapped reads give zero
        if (WR) begin
            case (ADDR)
                ADDR_ANALOG_DATA: begin
                    next_r.analog_data   = WDATA;
                    next_r.analog_loaded = 1'b1;                                  // arms the retention check
                end
                ADDR_CLOCK_DATA:  next_r.clock_data  = WDATA[CLOCK_W-1:0];
                ADDR_SEVEN_DATA:  next_r.seven_data  = WDATA[SEVEN_W-1:0];
                ADDR_ANALOG_DIR:  next_r.analog_dir  = WDATA;
                ADDR_CLOCK_DIR: begin
                    next_r.clock_dir  = WDATA[CLOCK_W-1:0];
                    next_r.clk_out_en = WDATA[CLK_OUT_EN_BIT];
                end
                ADDR_SEVEN_DIR:   next_r.seven_dir   = WDATA[SEVEN_W-1:0];
                ADDR_CHAN_SEL:    next_r.chan_sel    = WDATA[CHAN_W-1:0];
                default: ;                               // unmapped writes ignored
            endcase
        end
        if (RD) begin
            case (ADDR)
                ADDR_ANALOG_DATA: next_r.rdata = port_read(r.analog_data, r.analog_dir,
                                                 analog_sync, analog_chan);
                ADDR_CLOCK_DATA:  next_r.rdata = clock_read;
                ADDR_SEVEN_DATA:  next_r.rdata = port_read({1'b0, r.seven_data},
                                                 {1'b0, r.seven_dir}, {1'b0, seven_sync},
                                                 {1'b0, seven_chan});
                ADDR_ANALOG_DIR:  next_r.rdata = r.analog_dir;
                ADDR_CLOCK_DIR:   next_r.rdata = {r.clk_out_en, 2'h0, r.clock_dir};
                ADDR_SEVEN_DIR:   next_r.rdata = {1'b0, r.seven_dir};
                ADDR_CHAN_SEL:    next_r.rdata = {3'h0, r.chan_sel};
                default:          next_r.rdata = 8'h00;
            endcase
        end
    end

    // register; reset clears direction, clock enable and read data and loads chan_sel with CHAN_RESET; latches keep their contents
    always_ff @(posedge CLK) begin
        r <= next_r;
        if (RESET) begin
            r.analog_dir <= DIR_RESET[ANALOG_W-1:0];
            r.clock_dir  <= DIR_RESET[CLOCK_W-1:0];
            r.clk_out_en <= 1'b0;
            r.seven_dir  <= DIR_RESET[SEVEN_W-1:0];
            r.chan_sel   <= CHAN_RESET;
            r.rdata      <= 8'h00;
        end
    end

    // pin drivers; converter pins never driven, whatever their direction bit
    always_comb begin
        ANALOG_PIN_OUT  = r.analog_data;
        ANALOG_PIN_OE_N = ~(r.analog_dir & ~analog_chan);
        SEVEN_PIN_OUT   = r.seven_data;
        SEVEN_PIN_OE_N  = ~(r.seven_dir & ~seven_chan);
        CLOCK_PIN_OUT   = r.clock_data;
        CLOCK_PIN_OE_N  = ~r.clock_dir;
        if (r.clk_out_en) begin
            CLOCK_PIN_OUT[CLK_PIN_BIT]  = CLK;
            CLOCK_PIN_OE_N[CLK_PIN_BIT] = 1'b0;
        end
    end
    // latches are not reset; software loads them before raising direction
    assign RDATA                    = r.rdata;
    assign CONVERTER_CHANNEL_SELECT = r.chan_sel;

    // checks; each one watches state or outputs that this block drives

    // reset makes every pin an input, whatever was driven before
    AST_DIR_RESET: assert property (@(posedge CLK) RESET |=>
        ANALOG_PIN_OE_N == 8'hff && SEVEN_PIN_OE_N == 7'h7f && CLOCK_PIN_OE_N == 5'h1f)
        else $error("pins not inputs after reset");
    // reset clears the other direction bits and the clock output too
    AST_DIR_CLEAR: assert property (@(posedge CLK) RESET |=>
        r.seven_dir == 7'h00 && r.clock_dir == 5'h00 && !r.clk_out_en)
        else $error("direction bits survive reset");
    // the latch powers up unknown and is never cleared, so the check arms only
    // once software has loaded it; from then on reset must leave it alone
    AST_LATCH_KEEP: assert property (@(posedge CLK) RESET && !WR && r.analog_loaded |=>
        r.analog_data == $past(r.analog_data))
        else $error("reset disturbed latch");

    // latches take every write, whatever the direction bit
    AST_WRITE_ANY: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_ANALOG_DATA |=> r.analog_data == $past(WDATA))
        else $error("latch write lost");
    // clock-port latch keeps the low five bits of the write
    AST_WRITE_CLOCK: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_CLOCK_DATA |=> r.clock_data == $past(WDATA[CLOCK_W-1:0]))
        else $error("clock-port latch write lost");
    // seven-bit latch keeps the low seven bits of the write
    AST_WRITE_SEVEN: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_SEVEN_DATA |=> r.seven_data == $past(WDATA[SEVEN_W-1:0]))
        else $error("seven-bit latch write lost");
    // analog direction takes the whole byte
    AST_DIR_WRITE: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_ANALOG_DIR |=> r.analog_dir == $past(WDATA))
        else $error("direction write lost");

    // an input pin is never driven, on the analog port
    AST_ANALOG_FLOAT: assert property (@(posedge CLK) disable iff (RESET)
        (~ANALOG_PIN_OE_N & ~r.analog_dir) == 8'h00)
        else $error("analog input pin driven");
    // same for the seven-bit port
    AST_SEVEN_FLOAT: assert property (@(posedge CLK) disable iff (RESET)
        (~SEVEN_PIN_OE_N & ~r.seven_dir) == 7'h00)
        else $error("seven-bit input pin driven");
    // clock port: only the clock output may override a cleared direction bit
    AST_CLOCK_FLOAT: assert property (@(posedge CLK) disable iff (RESET)
        !r.clk_out_en |-> (~CLOCK_PIN_OE_N & ~r.clock_dir) == 5'h00)
        else $error("clock-port input pin driven");
    // an output pin outside converter use is really driven
    AST_OUTPUT_DRIVE: assert property (@(posedge CLK) disable iff (RESET)
        (r.analog_dir & ~analog_chan & ANALOG_PIN_OE_N) == 8'h00)
        else $error("analog output pin not driven");
    // converter pins stay undriven whatever their direction bit
    AST_CHAN_NODRIVE: assert property (@(posedge CLK) disable iff (RESET)
        analog_chan != 8'h00 |-> (ANALOG_PIN_OE_N & analog_chan) == analog_chan)
        else $error("converter pin driven");
    // same on the seven-bit port
    AST_SEVEN_NODRIVE: assert property (@(posedge CLK) disable iff (RESET)
        seven_chan != 7'h00 |-> (SEVEN_PIN_OE_N & seven_chan) == seven_chan)
        else $error("seven-bit converter pin driven");

    // a valid channel code claims exactly one pin
    AST_CHAN_PICK: assert property (@(posedge CLK) disable iff (RESET)
        r.chan_sel < CHAN_COUNT |-> $onehot({seven_chan, analog_chan}))
        else $error("channel code claims no single pin");
    // codes past the last channel leave every pin to the port
    AST_CHAN_NONE: assert property (@(posedge CLK) disable iff (RESET)
        r.chan_sel >= CHAN_COUNT |-> {seven_chan, analog_chan} == 15'h0000)
        else $error("out-of-range code claims a pin");
    // low codes land on the analog port, in pin order
    AST_CHAN_LOW_MAP: assert property (@(posedge CLK) disable iff (RESET)
        r.chan_sel < CHAN_HIGH_BASE |-> analog_chan == (8'h01 << r.chan_sel[2:0]))
        else $error("low channel on wrong pin");
    // high codes land on the seven-bit port, in pin order
    AST_CHAN_HIGH_MAP: assert property (@(posedge CLK) disable iff (RESET)
        r.chan_sel >= CHAN_HIGH_BASE && r.chan_sel < CHAN_COUNT |->
        seven_chan == (7'h01 << (r.chan_sel - CHAN_HIGH_BASE)))
        else $error("high channel on wrong pin");
    // select register shows up on its output the cycle after the write
    AST_CHAN_WRITE: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_CHAN_SEL |=> CONVERTER_CHANNEL_SELECT == $past(WDATA[CHAN_W-1:0]))
        else $error("channel select write lost");

    // analog read: latch where output, pin where input, zero on the channel pin where it is an input
    AST_ANALOG_RD: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_ANALOG_DATA |=> RDATA == (($past(r.analog_dir) & $past(r.analog_data)) |
        (~$past(r.analog_dir) & $past(analog_sync) & ~$past(analog_chan))))
        else $error("analog read wrong");
    // the selected channel reads zero while its direction bit is clear
    AST_ANALOG_CHAN_ZERO: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_ANALOG_DATA |=> (RDATA & $past(analog_chan & ~r.analog_dir)) == 8'h00)
        else $error("analog channel pin not zero");
    // first seven-bit channel, as an input, reads zero
    AST_CHAN_ZERO: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_SEVEN_DATA && r.chan_sel == CHAN_HIGH_BASE && !r.seven_dir[0] |=>
        RDATA[0] == 1'b0)
        else $error("channel pin not zero");
    // seven-bit read follows the same latch or pin choice
    AST_SEVEN_RD: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_SEVEN_DATA |=> RDATA[SEVEN_W-1:0] == (($past(r.seven_dir) & $past(r.seven_data)) |
        (~$past(r.seven_dir) & $past(seven_sync) & ~$past(seven_chan))))
        else $error("seven-bit read wrong");
    // clock-port output bit reads its latch
    AST_CLOCK_RD: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_CLOCK_DATA && !r.clk_out_en && r.clock_dir[0] |=>
        RDATA[0] == $past(r.clock_data[0]))
        else $error("clock port read wrong");
    // while the clock is out, its pin reads zero
    AST_CLK_PIN_RD: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == ADDR_CLOCK_DATA && r.clk_out_en |=> RDATA[CLK_PIN_BIT] == 1'b0)
        else $error("clock pin read not zero");
    // setting the enable drives the pin from the next cycle
    AST_CLK_OUT: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == ADDR_CLOCK_DIR && WDATA[CLK_OUT_EN_BIT] |=> !CLOCK_PIN_OE_N[CLK_PIN_BIT])
        else $error("clock output not enabled");
    // and the pin stays driven as long as the enable is set
    AST_CLK_DRIVEN: assert property (@(posedge CLK) disable iff (RESET)
        r.clk_out_en |-> !CLOCK_PIN_OE_N[CLK_PIN_BIT])
        else $error("clock pin released while enabled");
    // read data stand one cycle only, zero otherwise
    AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (RESET)
        !RD |=> RDATA == 8'h00)
        else $error("read data outside answer cycle");

    // main scenarios worth seeing at least once
    COV_ANALOG_OUT: cover property (@(posedge CLK) WR && ADDR == ADDR_ANALOG_DIR && WDATA != 8'h00);
    COV_CHAN_RD:    cover property (@(posedge CLK) RD && ADDR == ADDR_ANALOG_DATA && analog_chan != 8'h00);
    COV_CLK_OUT:    cover property (@(posedge CLK) r.clk_out_en);
    COV_SEVEN_CHAN: cover property (@(posedge CLK) RD && ADDR == ADDR_SEVEN_DATA && seven_chan != 7'h00);
    COV_LOADED_RST: cover property (@(posedge CLK) RESET && r.analog_loaded);
endmodule : adc_shared_gpio_ports_bcd

/* File: hw/chan_decode.sv */
`timescale 1ns/1ps
// one-hot decode of the converter channel select over 15 pins
module chan_decode (
    input  wire logic [4:0]  SEL,
    output logic      [14:0] HOT
);
    import gpio_pkg::*;

    // codes at or beyond the channel count select no pin
    always_comb begin
        HOT = '0;
        if (SEL < CHAN_COUNT) begin
            HOT[SEL[3:0]] = 1'b1;
        end
    end
endmodule : chan_decode

/* File: hw/gpio_pkg.sv */
package gpio_pkg;
    // register indices on the plain bus (8-bit data)
    localparam logic [3:0] ADDR_ANALOG_DATA  = 4'h1;     // analog_port_data
    localparam logic [3:0] ADDR_CLOCK_DATA   = 4'h2;     // clock_port_data
    localparam logic [3:0] ADDR_SEVEN_DATA   = 4'h3;     // seven_bit_port_data
    localparam logic [3:0] ADDR_ANALOG_DIR   = 4'h5;     // analog_port_direction
    localparam logic [3:0] ADDR_CLOCK_DIR    = 4'h6;     // clock_port_direction
    localparam logic [3:0] ADDR_SEVEN_DIR    = 4'h7;     // seven_bit_port_direction
    localparam logic [3:0] ADDR_CHAN_SEL     = 4'h8;     // converter_channel_select
    // widths
    localparam int ANALOG_W = 8;
    localparam int CLOCK_W  = 5;
    localparam int SEVEN_W  = 7;
    localparam int CHAN_W   = 5;
    // field positions
    localparam int CLK_OUT_EN_BIT = 7;                   // sys_clock_out_enable
    localparam int CLK_PIN_BIT    = 2;                   // clock_port_pin_two
    // converter channel numbering
    localparam logic [4:0] CHAN_HIGH_BASE = 5'h08;       // first channel on seven-bit port
    localparam logic [4:0] CHAN_COUNT     = 5'h0f;       // fifteen channels
    // reset values
    localparam logic [7:0] DIR_RESET  = 8'h00;
    localparam logic [4:0] CHAN_RESET = 5'h1f;           // no pin channel selected
endpackage : gpio_pkg

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a bank of pin inputs
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         CLK,
    input  wire logic         RESET,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);
    logic [W-1:0] meta;                                  // first stage, read only by second

    // both stages clear on reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            meta <= '0;
            Q    <= '0;
        end else begin
            meta <= D;
            Q    <= meta;
        end
    end
endmodule : pin_sync

/* File: tb/adc_shared_gpio_ports_bcd_test.sv */
`timescale 1ns/1ps
module adc_shared_gpio_ports_bcd_test;
    import gpio_pkg::*;
    logic       CLK, RESET, WR, RD, rd_seen;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, a_out, a_oe_n, a_in, a_lvl, la, da, hot_a;
    logic [4:0] c_out, c_oe_n, c_in, c_lvl, lc, dc, chan;
    logic [6:0] s_out, s_oe_n, s_in, s_lvl, ls, ds, hot_s;
    logic [7:0] exp_q[$];           // expected read data, oldest first
    int         fail_count, cmp_count, cycles;

    adc_shared_gpio_ports_bcd dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ANALOG_PIN_IN(a_in), .ANALOG_PIN_OUT(a_out), .ANALOG_PIN_OE_N(a_oe_n),
        .CLOCK_PIN_IN(c_in), .CLOCK_PIN_OUT(c_out), .CLOCK_PIN_OE_N(c_oe_n), .SEVEN_PIN_IN(s_in),
        .SEVEN_PIN_OUT(s_out), .SEVEN_PIN_OE_N(s_oe_n), .CONVERTER_CHANNEL_SELECT(chan));
    board_model #(.W(8)) pa (.PIN_OUT(a_out), .PIN_OE_N(a_oe_n), .LEVEL(a_lvl), .PIN_IN(a_in));
    board_model #(.W(5)) pc (.PIN_OUT(c_out), .PIN_OE_N(c_oe_n), .LEVEL(c_lvl), .PIN_IN(c_in));
    board_model #(.W(7)) ps (.PIN_OUT(s_out), .PIN_OE_N(s_oe_n), .LEVEL(s_lvl), .PIN_IN(s_in));

    // free-running clock, 4 ns period
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic wrap_up;
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        cmp_count++;
        if (got !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask : chk

    // one-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    // read strobe; the note goes in the queue before the answer can appear
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        exp_q.push_back(e);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
    endtask : rd

    // watcher: read data stand only in the cycle after the strobe
    always @(posedge CLK) begin
        if (rd_seen) chk(RDATA, exp_q.pop_front());
        else if (!RESET) chk(RDATA, 8'h00);     // no answer pending: bus reads zero
        rd_seen <= RD;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic do_reset;
        RESET <= 1'b1;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        rd(ADDR_ANALOG_DIR, 8'h00);
        rd(ADDR_CLOCK_DIR, 8'h00);
        rd(ADDR_SEVEN_DIR, 8'h00);
        rd(ADDR_CHAN_SEL, {3'h0, CHAN_RESET});
        rd(4'hf, 8'h00);
        chk(a_oe_n, 8'hff);
        chk({3'h0, c_oe_n}, 8'h1f);
        chk({1'h0, s_oe_n}, 8'h7f);
    endtask : do_reset

    initial begin
        {RESET, WR, RD, ADDR, WDATA, a_lvl, c_lvl, s_lvl, rd_seen} = '0;
        void'($urandom(32'h834b));
        do_reset();
        $display("test reset state done");
        // random latch, direction and board levels on every port
        repeat (4) begin
            {la, da, lc, dc, ls, ds} = {8'($urandom), 8'($urandom), 5'($urandom), 5'($urandom), 14'($urandom)};
            a_lvl <= 8'($urandom);
            c_lvl <= 5'($urandom);
            s_lvl <= 7'($urandom);
            wr(ADDR_ANALOG_DATA, la);
            wr(ADDR_CLOCK_DATA, {3'h7, lc});
            wr(ADDR_SEVEN_DATA, {1'h1, ls});
            wr(ADDR_ANALOG_DIR, da);
            wr(ADDR_CLOCK_DIR, {3'h0, dc});
            wr(ADDR_SEVEN_DIR, {1'h0, ds});
            repeat (3) @(posedge CLK);
            rd(ADDR_ANALOG_DATA, (la & da) | (a_lvl & ~da));
            rd(ADDR_CLOCK_DATA, {3'h0, (lc & dc) | (c_lvl & ~dc)});
            rd(ADDR_SEVEN_DATA, {1'h0, (ls & ds) | (s_lvl & ~ds)});
            rd(ADDR_CLOCK_DIR, {3'h0, dc});
            chk(a_oe_n, ~da);
            chk({3'h0, c_oe_n}, {3'h0, ~dc});
            chk({1'h0, s_oe_n}, {1'h0, ~ds});
            chk(a_out, la);
            chk({3'h0, c_out}, {3'h0, lc});
            chk({1'h0, s_out}, {1'h0, ls});
            // clock out on: pin two driven by the clock and read as zero
            wr(ADDR_CLOCK_DIR, {3'h4, dc});
            repeat (3) @(posedge CLK);
            rd(ADDR_CLOCK_DATA, {3'h0, (lc & dc) | (c_lvl & ~dc)} & 8'hfb);
            rd(ADDR_CLOCK_DIR, {3'h4, dc});
            chk({7'h0, c_oe_n[2]}, 8'h00);
            @(negedge CLK);
            #1 chk({7'h0, c_out[2]}, 8'h00);
            @(posedge CLK);
            #1 chk({7'h0, c_out[2]}, 8'h01);
        end
        $display("test port directions done");
        // walk channel select codes 0 to 15; board pulls all analog and seven-bit pins high
        a_lvl <= 8'hff;
        s_lvl <= 7'h7f;
        wr(ADDR_ANALOG_DIR, 8'h0f);
        wr(ADDR_SEVEN_DIR, 8'h0f);
        for (int ch = 0; ch < 16; ch++) begin
            hot_a = (ch < 8) ? 8'h01 << ch : 8'h00;
            hot_s = (ch >= 8 && ch < 15) ? 7'h01 << (ch - 8) : 7'h00;
            wr(ADDR_CHAN_SEL, 8'(ch));
            repeat (3) @(posedge CLK);
            rd(ADDR_ANALOG_DATA, (la & 8'h0f) | (8'hf0 & ~hot_a));
            rd(ADDR_SEVEN_DATA, {1'h0, (ls & 7'h0f) | (7'h70 & ~hot_s)});
            chk(a_oe_n, 8'hf0 | hot_a);
            chk({1'h0, s_oe_n}, {1'h0, 7'h70 | hot_s});
            chk({3'h0, chan}, 8'(ch));
        end
        $display("test channel select done");
        // latches must survive a reset in mid-run
        do_reset();
        wr(ADDR_ANALOG_DIR, 8'hff);
        wr(ADDR_CLOCK_DIR, 8'h1f);
        wr(ADDR_SEVEN_DIR, 8'h7f);
        rd(ADDR_ANALOG_DATA, la);
        rd(ADDR_CLOCK_DATA, {3'h0, lc});
        rd(ADDR_SEVEN_DATA, {1'h0, ls});
        repeat (2) @(posedge CLK);
        $display("test latch retention done");
        wrap_up();
    end
endmodule : adc_shared_gpio_ports_bcd_test

/* File: tb/board_model.sv */
`timescale 1ns/1ps
// board side of one port: set levels, overridden where the chip drives
module board_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] PIN_OUT,
    input  wire logic [W-1:0] PIN_OE_N,
    input  wire logic [W-1:0] LEVEL,
    output logic      [W-1:0] PIN_IN
);
    // wire level per pin; the chip wins only where its enable is low
    always_comb begin
        for (int i = 0; i < W; i++) begin
            PIN_IN[i] = PIN_OE_N[i] ? LEVEL[i] : PIN_OUT[i];
        end
    end
endmodule : board_model
